// [design/mpw_top.sv]
// Motor PWM unit: time base, trigger, dead time, override and fault A.
// Assumes APB master, clk is the instruction clock, inputs synchronous.
//
// Notes on behaviour
// - Counter register top bit reads one when counting down, zero up.
// - Count is 15 bits in counter low bits, readable and writable.
// - Period is 15 writable bits; top bit reads zero.
// - Trigger fires when compare value equals the 15-bit count.
// - Trigger direction bit must match the count direction flag.
// - 4-bit postscaler: code n passes one trigger per n+1 events.
// - Per pair mode bit: one independent, zero complementary outputs.
// - Each high and low pin has enable; zero releases it to GPIO.
// - Pin enables reset to a value set by the power-on fuse.
// - Immediate bit applies duty writes at once, else at boundary.
// - Override sync bit delays overrides to boundary, else next clock.
// - Block bit stops duty and period buffer transfers.
// - Each dead-time unit ticks every 1, 2, 4 or 8 clocks.
// - Each unit times dead time with a 6-bit tick count.
// - Per generator and edge, select bit picks unit B or A.
// - Eight fault A override bits force each pin active or inactive.
// - Fault A mode one is cycle-by-cycle, zero latches the fault.
// - Fault A acts on a pair only when its enable bit is set.
// - Complementary low side is inverse of high with dead time.
// - Four time base styles: free, single pulse, up/down, double.
// - Fault A takes priority over fault B on the same pair.
//
// The register addresses and the APB slave port were left to the implementer.
module mpw_top (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             pinOwnershipFuse,
  input  wire logic [3:0][15:0] dutyCompareValue,
  input  wire logic [3:0]       dutyWrite,
  input  wire logic [7:0]       overrideEnable,
  input  wire logic [7:0]       overrideValue,
  input  wire logic             overrideWrite,
  input  wire logic             faultOneIn,
  input  wire logic [3:0]       faultTwoActive,
  input  wire logic [7:0]       faultTwoDrive,
  output logic      [3:0]       highSideOutput,
  output logic      [3:0]       lowSideOutput,
  output logic      [3:0]       highPinEnable,
  output logic      [3:0]       lowPinEnable,
  output logic                  triggerOut,
  output logic                  countDownFlag
);

  typedef struct packed {
    logic             ack;
    logic             err;
    logic [31:0]      rdata;
    logic [14:0]      cnt;
    logic             dir;
    logic [14:0]      per;
    logic [14:0]      perBuf;
    logic [15:0]      cmp;
    logic [3:0]       pairMode;
    logic [3:0]       highEn;
    logic [3:0]       lowEn;
    logic [3:0]       postSel;
    logic             immUpd;
    logic             ovSync;
    logic             xferBlock;
    logic [1:0]       dbAPs;
    logic [5:0]       dbACnt;
    logic [1:0]       dbBPs;
    logic [5:0]       dbBCnt;
    logic [7:0]       dbSel;
    logic [7:0]       faOv;
    logic             faMode;
    logic [3:0]       faEn;
    logic             run;
    logic [1:0]       style;
    logic [3:0][15:0] duty;
    logic [3:0][15:0] dutyBuf;
    logic [7:0]       ovEn;
    logic [7:0]       ovVal;
    logic [7:0]       ovEnP;
    logic [7:0]       ovValP;
    logic             ovPend;
    logic [2:0]       pscA;
    logic [2:0]       pscB;
    logic [3:0]       rawPrev;
    logic [3:0][5:0]  dly;
    logic [3:0]       dlyUnit;
    logic             faLatch;
    logic [3:0]       postCnt;
    logic             trig;
    logic [3:0]       hOut;
    logic [3:0]       lOut;
  } mpw_state_t;

  mpw_state_t s_r;
  mpw_state_t s_nxt;

  function automatic logic regMapped(input logic [7:0] a);
    unique case (a)
      mpw_pkg::OFS_COUNTER, mpw_pkg::OFS_PERIOD, mpw_pkg::OFS_TRIGCMP,
      mpw_pkg::OFS_PAIRCTL, mpw_pkg::OFS_UPDCTL, mpw_pkg::OFS_DBTIME,
      mpw_pkg::OFS_DBSEL, mpw_pkg::OFS_FAULTA,
      mpw_pkg::OFS_TBMODE: regMapped = 1'b1;
      default:             regMapped = 1'b0;
    endcase
  endfunction

  // Prescaled tick: true when the free counter's low bits are zero
  function automatic logic dbTick(input logic [2:0] psc,
                                  input logic [1:0] ps);
    logic [2:0] mask;
    unique case (ps)
      2'h0: mask = mpw_pkg::PS_MASK_1;
      2'h1: mask = mpw_pkg::PS_MASK_2;
      2'h2: mask = mpw_pkg::PS_MASK_4;
      2'h3: mask = mpw_pkg::PS_MASK_8;
    endcase
    dbTick = (psc & mask) == 3'h0;
  endfunction

  logic        apbSetup;
  logic        apbWrite;
  logic        boundary;
  logic        faultOneOn;
  logic        rawPwm;
  logic        edgeUnit;
  logic [5:0]  edgeLoad;
  logic        blank;
  logic        genH;
  logic        genL;
  logic        pinH;
  logic        pinL;
  logic        unitTick;
  logic [15:0] rdWord;
  logic [15:0] wd;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.trig = 1'b0;
    apbSetup   = psel & ~penable;
    apbWrite   = psel & penable & s_r.ack & pwrite;
    wd         = pwdata[15:0];
    boundary   = 1'b0;
    rawPwm     = 1'b0;
    edgeUnit   = 1'b0;
    edgeLoad   = 6'h00;
    blank      = 1'b0;
    genH       = 1'b0;
    genL       = 1'b0;
    pinH       = 1'b0;
    pinL       = 1'b0;
    unitTick   = 1'b0;

    // Read data captured in setup, answered in the first access cycle
    unique case (paddr)
      mpw_pkg::OFS_COUNTER: rdWord = {s_r.dir, s_r.cnt};
      mpw_pkg::OFS_PERIOD:  rdWord = {1'b0, s_r.perBuf};
      mpw_pkg::OFS_TRIGCMP: rdWord = s_r.cmp;
      mpw_pkg::OFS_PAIRCTL:
        rdWord = {4'h0, s_r.pairMode, s_r.highEn, s_r.lowEn};
      mpw_pkg::OFS_UPDCTL:
        rdWord = {4'h0, s_r.postSel, 5'h00, s_r.immUpd, s_r.ovSync,
                  s_r.xferBlock};
      mpw_pkg::OFS_DBTIME:
        rdWord = {s_r.dbBPs, s_r.dbBCnt, s_r.dbAPs, s_r.dbACnt};
      mpw_pkg::OFS_DBSEL:   rdWord = {8'h00, s_r.dbSel};
      mpw_pkg::OFS_FAULTA:
        rdWord = {s_r.faOv, s_r.faMode, 3'h0, s_r.faEn};
      mpw_pkg::OFS_TBMODE:
        rdWord = {s_r.run, 13'h0000, s_r.style};
      default:              rdWord = mpw_pkg::RST_WORD;
    endcase
    if (apbSetup) begin
      s_nxt.ack   = 1'b1;
      s_nxt.err   = ~regMapped(paddr);
      s_nxt.rdata = {16'h0000, rdWord};
    end else if (psel & penable & s_r.ack) begin
      s_nxt.ack = 1'b0;
    end

    // Time base
    if (s_r.run) begin
      unique case (mpw_pkg::mpw_style_t'(s_r.style))
        mpw_pkg::STYLE_FREE, mpw_pkg::STYLE_SINGLE: begin
          s_nxt.dir = 1'b0;
          if (s_r.cnt >= s_r.per) begin
            s_nxt.cnt = '0;
            boundary  = 1'b1;
            if (s_r.style == mpw_pkg::STYLE_SINGLE) begin
              s_nxt.run = 1'b0;
            end
          end else begin
            s_nxt.cnt = s_r.cnt + 15'h0001;
          end
        end
        mpw_pkg::STYLE_UPDOWN, mpw_pkg::STYLE_UPDOWN_DBL: begin
          if (!s_r.dir) begin
            if (s_r.cnt >= s_r.per) begin
              s_nxt.dir = 1'b1;
              if (s_r.cnt != '0) begin
                s_nxt.cnt = s_r.cnt - 15'h0001;
              end
              boundary = s_r.style ==
                         mpw_pkg::STYLE_UPDOWN_DBL;
            end else begin
              s_nxt.cnt = s_r.cnt + 15'h0001;
            end
          end else if (s_r.cnt == '0) begin
            s_nxt.dir = 1'b0;
            if (s_r.per != '0) begin
              s_nxt.cnt = 15'h0001;
            end
            boundary = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 15'h0001;
          end
        end
      endcase
    end

    // Buffer transfers: at boundary, or at once while stopped
    if ((boundary | ~s_r.run) & ~s_r.xferBlock) begin
      s_nxt.per  = s_r.perBuf;
      s_nxt.duty = s_r.dutyBuf;
    end
    for (int i = 0; i < mpw_pkg::NUM_PAIRS; i++) begin
      if (dutyWrite[i]) begin
        s_nxt.dutyBuf[i] = dutyCompareValue[i];
        if (s_r.immUpd & ~s_r.xferBlock) begin
          s_nxt.duty[i] = dutyCompareValue[i];
        end
      end
    end

    // Override staging
    if (boundary & s_r.ovPend) begin
      s_nxt.ovEn   = s_r.ovEnP;
      s_nxt.ovVal  = s_r.ovValP;
      s_nxt.ovPend = 1'b0;
    end
    if (overrideWrite) begin
      if (s_r.ovSync) begin
        s_nxt.ovEnP  = overrideEnable;
        s_nxt.ovValP = overrideValue;
        s_nxt.ovPend = 1'b1;
      end else begin
        s_nxt.ovEn  = overrideEnable;
        s_nxt.ovVal = overrideValue;
      end
    end

    // Special event trigger with postscaler
    if (s_r.run && s_r.cnt == s_r.cmp[mpw_pkg::CNT_W-1:0]
        && s_r.dir == s_r.cmp[mpw_pkg::FLD_TRIGDIR]) begin
      if (s_r.postCnt == s_r.postSel) begin
        s_nxt.trig    = 1'b1;
        s_nxt.postCnt = 4'h0;
      end else begin
        s_nxt.postCnt = s_r.postCnt + 4'h1;
      end
    end

    // Fault A: set wins over any clear
    faultOneOn = faultOneIn | s_r.faLatch;
    if (faultOneIn) begin
      s_nxt.faLatch = 1'b1;
    end else if (s_r.faMode ? boundary
                 : (apbWrite && paddr == mpw_pkg::OFS_FAULTA)) begin
      s_nxt.faLatch = 1'b0;
    end

    // Dead-time prescalers run free
    s_nxt.pscA = s_r.pscA + 3'h1;
    s_nxt.pscB = s_r.pscB + 3'h1;

    // Generators, dead time, override, faults, pin enables
    for (int i = 0; i < mpw_pkg::NUM_PAIRS; i++) begin
      rawPwm = {1'b0, s_r.cnt} < s_r.duty[i];
      s_nxt.rawPrev[i] = rawPwm;
      if (s_r.pairMode[i]) begin
        genH         = rawPwm;
        genL         = rawPwm;
        s_nxt.dly[i] = 6'h00;
      end else begin
        if (rawPwm != s_r.rawPrev[i]) begin
          edgeUnit = rawPwm ? s_r.dbSel[2*i+1] : s_r.dbSel[2*i];
          edgeLoad = edgeUnit ? s_r.dbBCnt : s_r.dbACnt;
          s_nxt.dly[i]     = edgeLoad;
          s_nxt.dlyUnit[i] = edgeUnit;
          blank = edgeLoad != 6'h00;
        end else if (s_r.dly[i] != 6'h00) begin
          unitTick = s_r.dlyUnit[i] ? dbTick(s_r.pscB, s_r.dbBPs)
                                    : dbTick(s_r.pscA, s_r.dbAPs);
          if (unitTick) begin
            s_nxt.dly[i] = s_r.dly[i] - 6'h01;
          end
          blank = 1'b1;
        end
        genH = rawPwm & ~blank;
        genL = ~rawPwm & ~blank;
      end
      pinH = s_r.ovEn[2*i+1] ? genH : s_r.ovVal[2*i+1];
      pinL = s_r.ovEn[2*i]   ? genL : s_r.ovVal[2*i];
      if (s_r.faEn[i] & faultOneOn) begin
        pinH = s_r.faOv[2*i+1];
        pinL = s_r.faOv[2*i];
      end else if (faultTwoActive[i]) begin
        pinH = faultTwoDrive[2*i+1];
        pinL = faultTwoDrive[2*i];
      end
      s_nxt.hOut[i] = s_r.highEn[i] & pinH;
      s_nxt.lOut[i] = s_r.lowEn[i] & pinL;
    end

    // Register writes take effect at the completing access edge
    if (apbWrite) begin
      unique case (paddr)
        mpw_pkg::OFS_COUNTER: s_nxt.cnt = wd[mpw_pkg::CNT_W-1:0];
        mpw_pkg::OFS_PERIOD: s_nxt.perBuf = wd[mpw_pkg::CNT_W-1:0];
        mpw_pkg::OFS_TRIGCMP: s_nxt.cmp = wd;
        mpw_pkg::OFS_PAIRCTL: begin
          s_nxt.pairMode = wd[mpw_pkg::FLD_PAIR_INDEPENDENT_SELECT +: 4];
          s_nxt.highEn   = wd[mpw_pkg::FLD_HEN +: 4];
          s_nxt.lowEn    = wd[mpw_pkg::FLD_LEN +: 4];
        end
        mpw_pkg::OFS_UPDCTL: begin
          s_nxt.postSel   = wd[mpw_pkg::FLD_POST +: 4];
          s_nxt.immUpd    = wd[mpw_pkg::FLD_IUE];
          s_nxt.ovSync    = wd[mpw_pkg::FLD_OVERRIDE_SYNC];
          s_nxt.xferBlock = wd[mpw_pkg::FLD_BUFFER_TRANSFER_BLOCK];
        end
        mpw_pkg::OFS_DBTIME: begin
          s_nxt.dbBPs  = wd[mpw_pkg::FLD_DEADBAND_B_PRESCALE +: 2];
          s_nxt.dbBCnt = wd[mpw_pkg::FLD_DTB +: 6];
          s_nxt.dbAPs  = wd[mpw_pkg::FLD_DEADBAND_A_PRESCALE +: 2];
          s_nxt.dbACnt = wd[mpw_pkg::FLD_DTA +: 6];
        end
        mpw_pkg::OFS_DBSEL: s_nxt.dbSel = wd[7:0];
        mpw_pkg::OFS_FAULTA: begin
          s_nxt.faOv   = wd[mpw_pkg::FLD_FAOV +: 8];
          s_nxt.faMode = wd[mpw_pkg::FLD_FAM];
          s_nxt.faEn   = wd[mpw_pkg::FLD_FAEN +: 4];
        end
        mpw_pkg::OFS_TBMODE: begin
          s_nxt.run   = wd[mpw_pkg::FLD_RUN];
          s_nxt.style = wd[mpw_pkg::FLD_STYLE +: 2];
        end
        default: ;
      endcase
    end

    if (rst) begin
      s_nxt        = '0;
      s_nxt.ovEn   = mpw_pkg::RST_OVD_EN;
      s_nxt.highEn = {4{pinOwnershipFuse}};
      s_nxt.lowEn  = {4{pinOwnershipFuse}};
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign prdata         = (psel & penable & s_r.ack) ? s_r.rdata
                                                     : mpw_pkg::RD_ZERO;
  assign pready         = psel & penable & s_r.ack;
  assign pslverr        = psel & penable & s_r.ack & s_r.err;
  assign highSideOutput = s_r.hOut;
  assign lowSideOutput  = s_r.lOut;
  assign highPinEnable  = s_r.highEn;
  assign lowPinEnable   = s_r.lowEn;
  assign triggerOut     = s_r.trig;
  assign countDownFlag  = s_r.dir;

endmodule // mpw_top

// [inc/mpw_pkg.sv]
// Constants for the motor PWM time base, dead time and fault block.
// Assumes a 32-bit APB slave with each 16-bit register in one word.
package mpw_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_COUNTER  = 8'h00;
  localparam logic [7:0] OFS_PERIOD   = 8'h04;
  localparam logic [7:0] OFS_TRIGCMP  = 8'h08;
  localparam logic [7:0] OFS_PAIRCTL  = 8'h0C;
  localparam logic [7:0] OFS_UPDCTL   = 8'h10;
  localparam logic [7:0] OFS_DBTIME   = 8'h14;
  localparam logic [7:0] OFS_DBSEL    = 8'h18;
  localparam logic [7:0] OFS_FAULTA   = 8'h1C;
  localparam logic [7:0] OFS_TBMODE   = 8'h20;

  // Field positions
  localparam int unsigned CNT_W        = 15;
  localparam int unsigned FLD_DIR      = 15;
  localparam int unsigned FLD_TRIGDIR  = 15;
  localparam int unsigned FLD_PAIR_INDEPENDENT_SELECT     = 8;
  localparam int unsigned FLD_HEN      = 4;
  localparam int unsigned FLD_LEN      = 0;
  localparam int unsigned FLD_POST     = 8;
  localparam int unsigned FLD_IUE      = 2;
  localparam int unsigned FLD_OVERRIDE_SYNC    = 1;
  localparam int unsigned FLD_BUFFER_TRANSFER_BLOCK     = 0;
  localparam int unsigned FLD_DEADBAND_B_PRESCALE    = 14;
  localparam int unsigned FLD_DTB      = 8;
  localparam int unsigned FLD_DEADBAND_A_PRESCALE    = 6;
  localparam int unsigned FLD_DTA      = 0;
  localparam int unsigned FLD_FAOV     = 8;
  localparam int unsigned FLD_FAM      = 7;
  localparam int unsigned FLD_FAEN     = 0;
  localparam int unsigned FLD_RUN      = 15;
  localparam int unsigned FLD_STYLE    = 0;
  localparam int unsigned NUM_PAIRS    = 4;

  // Reset values
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [7:0]  RST_OVD_EN   = 8'hFF;
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

  // Dead-time prescale masks: 1, 2, 4, 8 clocks per tick
  localparam logic [2:0]  PS_MASK_1    = 3'h0;
  localparam logic [2:0]  PS_MASK_2    = 3'h1;
  localparam logic [2:0]  PS_MASK_4    = 3'h3;
  localparam logic [2:0]  PS_MASK_8    = 3'h7;

  typedef enum logic [1:0] {
    STYLE_FREE,
    STYLE_SINGLE,
    STYLE_UPDOWN,
    STYLE_UPDOWN_DBL
  } mpw_style_t;

endpackage

// [sim/mpw_check_sva.sv]
// Checker for the motor PWM unit: bus timing, pin enables, pin overlap.
// Assumes it is bound to mpw_top and sees only the top's ports.
module mpw_check (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pinOwnershipFuse,
  input wire logic [3:0]  highSideOutput,
  input wire logic [3:0]  lowSideOutput,
  input wire logic [3:0]  highPinEnable,
  input wire logic [3:0]  lowPinEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] modeR;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence apbAcc;
    psel && penable;
  endsequence
  // Pair mode shadow, taken from completed writes
  always_ff @(posedge clk) begin
    if (rst) begin
      modeR <= 4'h0;
    end else if (pready && pwrite && paddr == mpw_pkg::OFS_PAIRCTL) begin
      modeR <= pwdata[11:8];
    end
  end
  ready_timing_a: assert property (apbAcc |-> pready)
    else $error("access cycle without ready");
  error_map_a: assert property (apbAcc |->
    pslverr == (paddr > mpw_pkg::OFS_TBMODE || paddr[1:0] != 2'h0))
    else $error("error response does not match address");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  fuse_reset_a: assert property ($fell(rst) |->
    highPinEnable == {4{$past(pinOwnershipFuse)}} &&
    lowPinEnable == {4{$past(pinOwnershipFuse)}})
    else $error("pin enables not reset from fuse");
  pin_quiet_a: assert property (
    $stable(highPinEnable) && $stable(lowPinEnable) |->
    ((highSideOutput & ~highPinEnable) | (lowSideOutput & ~lowPinEnable))
    == 4'h0)
    else $error("released pin driven");
  enable_write_a: assert property (
    $changed({highPinEnable, lowPinEnable}) |->
    $past(pready && pwrite && paddr == mpw_pkg::OFS_PAIRCTL))
    else $error("pin enables changed without write");
  no_overlap_a: assert property ($stable(modeR) |->
    (highSideOutput & lowSideOutput & ~modeR) == 4'h0)
    else $error("complementary pins both active");
endmodule // mpw_check

bind mpw_top mpw_check u_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pinOwnershipFuse(pinOwnershipFuse),
  .highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput),
  .highPinEnable(highPinEnable), .lowPinEnable(lowPinEnable)
);

// [sim/mpw_gate_model.sv]
// Gate driver model: fault comparator output and pair 3 pin monitor.
// Assumes active high pins, sampled on the block clock.
module mpw_gate_model (
  input  wire logic       clk,
  input  wire logic       trip,
  input  wire logic       clr,
  input  wire logic [3:0] high,
  input  wire logic [3:0] low,
  output logic            faultOut,
  output int              highCnt,
  output int              gapCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Comparator reports a trip at once
  assign faultOut = trip;
  always_ff @(posedge clk) begin
    highCnt <= clr ? 0 : highCnt + int'(high[3]);
    gapCnt  <= clr ? 0 : gapCnt + int'(!high[3] && !low[3]);
  end
endmodule // mpw_gate_model

// [sim/mpw_top_test.sv]
// Testbench: register model, trigger timing, fault, override, dead time.
// Assumes the checker binds itself; gate model sits on the pins.
module mpw_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 9;
  logic             clk, rst, psel, penable, pwrite, pready, pslverr;
  logic             e, trip, clr, ovWr, trig, dn, flt, fuse;
  logic [7:0]       paddr, ovEn, ovVal, fbDrv;
  logic [31:0]      pwdata, prdata, r;
  logic [3:0][15:0] duty;
  logic [3:0]       dutyWr, hi, lo, hen, len, fb;
  logic [15:0]      mdl[9];
  logic [15:0]      msk[9] = '{16'h7FFF, 16'h7FFF, 16'hFFFF, 16'h0FFF,
    16'h0F07, 16'hFFFF, 16'h00FF, 16'hFF8F, 16'h8003};
  logic [3:0]       ps[3] = '{4'h0, 4'h1, 4'hF};
  int               bad_count, check_count, n, hc, gc;

  mpw_top u_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinOwnershipFuse(fuse), .dutyCompareValue(duty),
    .dutyWrite(dutyWr), .overrideEnable(ovEn), .overrideValue(ovVal),
    .overrideWrite(ovWr), .faultOneIn(flt), .faultTwoActive(fb),
    .faultTwoDrive(fbDrv), .highSideOutput(hi), .lowSideOutput(lo),
    .highPinEnable(hen), .lowPinEnable(len), .triggerOut(trig),
    .countDownFlag(dn)
  );
  mpw_gate_model u_gate (
    .clk(clk), .trip(trip), .clr(clr), .high(hi), .low(lo),
    .faultOut(flt), .highCnt(hc), .gapCnt(gc)
  );

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(a, 1'b1, d);
    mdl[a[5:2]] = d & msk[a[5:2]];
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 16'h0000);
    chk(r, {16'h0000, mdl[a[5:2]]});
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic gap(output int c);
    c = 0;
    while (trig !== 1'b1 && c < 500) begin
      @(posedge clk);
      c++;
    end
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (trig !== 1'b1 && c < 500);
  endtask
  task automatic zap;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic pins(input logic [7:0] x);
    chk({24'h00_0000, hi, lo}, {24'h00_0000, x});
  endtask
  task automatic ovr(input logic [7:0] en, input logic [7:0] v);
    ovEn <= en;
    ovVal <= v;
    ovWr <= 1'b1;
    @(posedge clk);
    ovWr <= 1'b0;
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test;
  end
  initial begin
    {psel, penable, pwrite, trip, clr, ovWr} = 6'h00;
    fuse = 1'b1;
    fb = 4'h0;
    fbDrv = 8'h00;
    rst = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    duty = '0;
    dutyWr = 4'h0;
    ovEn = 8'hFF;
    ovVal = 8'h00;
    mdl = '{default: 16'h0000};
    mdl[3] = 16'h00FF;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(8'(i * 4));
    xfer(8'h24, 1'b0, 16'h0000);
    chk({31'h0, e}, 32'h1);
    void'($urandom(32'h8979));
    for (int i = 0; i < 8; i++) begin
      wr(8'(i * 4), 16'($urandom));
      rd(8'(i * 4));
    end
    for (int i = 0; i < 8; i++) wr(8'(i * 4), 16'h0000);
    wr(mpw_pkg::OFS_PAIRCTL, 16'h00FF);
    wr(mpw_pkg::OFS_PERIOD, 16'(PER));
    wr(mpw_pkg::OFS_TRIGCMP, 16'h0005);
    foreach (ps[i]) begin
      wr(mpw_pkg::OFS_UPDCTL, {4'h0, ps[i], 8'h00});
      wr(mpw_pkg::OFS_TBMODE, 16'h8000);
      repeat (3) gap(n);
      chk(32'(n), 32'((ps[i] + 1) * (PER + 1)));
    end
    wr(mpw_pkg::OFS_UPDCTL, 16'h0000);
    for (int s = 2; s < 4; s++) for (int d = 0; d < 2; d++) begin
      wr(mpw_pkg::OFS_TRIGCMP, {d[0], 15'h0005});
      wr(mpw_pkg::OFS_TBMODE, 16'h8000 | 16'(s));
      repeat (3) gap(n);
      chk(32'(n), 32'(2 * PER));
      chk({31'h0, dn}, 32'(d));
    end
    wr(mpw_pkg::OFS_TBMODE, 16'h8001);
    wt(3 * PER);
    mdl[8] = 16'h0001;
    rd(mpw_pkg::OFS_TBMODE);
    wr(mpw_pkg::OFS_FAULTA, 16'h6605);
    trip <= 1'b1;
    wt(4);
    pins(8'h5A);
    trip <= 1'b0;
    wt(4);
    pins(8'h5A);
    wr(mpw_pkg::OFS_FAULTA, 16'h6605);
    wt(4);
    pins(8'h0F);
    wr(mpw_pkg::OFS_FAULTA, 16'h6685);
    wr(mpw_pkg::OFS_TBMODE, 16'h8000);
    trip <= 1'b1;
    wt(4);
    pins(8'h5A);
    trip <= 1'b0;
    wt(3 * PER);
    pins(8'h0F);
    // Fault B on all pairs; fault A wins on pairs 0 and 2
    fb <= 4'hF;
    fbDrv <= 8'h99;
    trip <= 1'b1;
    wt(4);
    pins(8'hF0);
    trip <= 1'b0;
    wt(3 * PER);
    pins(8'hA5);
    fb <= 4'h0;
    wr(mpw_pkg::OFS_TBMODE, 16'h0000);
    wr(mpw_pkg::OFS_UPDCTL, 16'h0002);
    ovr(8'h00, 8'h66);
    wt(20);
    pins(8'h0F);
    wr(mpw_pkg::OFS_TBMODE, 16'h8000);
    wt(3 * PER);
    pins(8'h5A);
    wr(mpw_pkg::OFS_UPDCTL, 16'h0000);
    ovr(8'hFF, 8'h00);
    wt(3);
    pins(8'h0F);
    wr(mpw_pkg::OFS_PAIRCTL, 16'h00F0);
    wt(3);
    pins(8'h00);
    wr(mpw_pkg::OFS_PAIRCTL, 16'h00FF);
    wr(mpw_pkg::OFS_PERIOD, 16'h0063);
    wt(3 * PER);
    wr(mpw_pkg::OFS_UPDCTL, 16'h0001);
    duty[3] <= 16'h0032;
    dutyWr <= 4'h8;
    @(posedge clk);
    dutyWr <= 4'h0;
    zap;
    wt(201);
    chk(32'(hc), 32'h0);
    wr(mpw_pkg::OFS_UPDCTL, 16'h0000);
    wt(201);
    zap;
    wt(101);
    chk(32'(hc), 32'h32);
    wr(mpw_pkg::OFS_DBTIME, 16'h0043);
    for (int k = 0; k < 2; k++) begin
      wr(mpw_pkg::OFS_DBSEL, k ? 16'h0080 : 16'h0000);
      wt(101);
      zap;
      wt(101);
      chk(32'(gc inside {[(2 - k) * 4 : (2 - k) * 7]}), 32'h1);
    end
    // Pair 3 independent: both pins follow the raw waveform
    wr(mpw_pkg::OFS_PAIRCTL, 16'h08FF);
    wt(3);
    zap;
    wt(101);
    chk(32'(hc), 32'h32);
    chk(32'(gc), 32'h32);
    // Mid-run reset with the fuse cleared
    fuse <= 1'b0;
    rst <= 1'b1;
    wt(5);
    rst <= 1'b0;
    wt(1);
    chk({24'h00_0000, hen, len}, 32'h0000_0000);
    mdl = '{default: 16'h0000};
    for (int i = 0; i < 9; i++) rd(8'(i * 4));
    stop_test;
  end
endmodule // mpw_top_test
